/* File: hdl/serial_reg_port.sv */
`timescale 1ns/10ps
module serial_reg_port
  import txpll_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial pins
  input wire logic spi_sck,
  input wire logic spi_nsel,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // Register side
  output reg_req_t req,
  input wire logic [7:0] rdata
);

  logic sck_q;
  logic [3:0] bit_cnt;
  logic [6:0] shift_in;
  logic is_write;
  logic load_pend;
  logic [7:0] tx_shift;
  logic rise;
  logic fall;

  assign rise = spi_sck & ~sck_q;
  assign fall = ~spi_sck & sck_q;
  assign spi_sdo = tx_shift[7];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= spi_sck;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame: direction bit, 7 address bits, then bytes; address increments after each written byte
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 4'h0;
      shift_in <= 7'h00;
      is_write <= 1'b0;
      req <= '0;
      load_pend <= 1'b0;
    end else begin
      req.wr <= 1'b0;
      load_pend <= 1'b0;
      if (spi_nsel) begin
        bit_cnt <= 4'h0;
      end else if (rise) begin
        shift_in <= {shift_in[5:0], spi_sdi};
        if (bit_cnt == 4'h7) begin
          is_write <= shift_in[6];
          req.addr <= {shift_in[5:0], spi_sdi};
          load_pend <= ~shift_in[6];
          bit_cnt <= 4'h8;
        end else if (bit_cnt == 4'hf) begin
          req.wr <= is_write;
          req.wdata <= {shift_in, spi_sdi};
          bit_cnt <= 4'h8;
          load_pend <= ~is_write;
        end else begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
      if (req.wr) begin
        req.addr <= req.addr + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, loaded one clock after the address byte so the new address has settled
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_shift <= 8'h00;
    end else if (spi_nsel) begin
      tx_shift <= 8'h00;
    end else if (load_pend) begin
      tx_shift <= rdata;
    end else if (fall && bit_cnt > 4'h8) begin
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

endmodule : serial_reg_port

/* File: hdl/tx_ramp_pll_calibration_ctrl.sv */
`timescale 1ns/10ps
// Overview of operation
// - Wait programmed delay after the PA ramp, before modulation
// - Same modulation delay applied during PA ramp-down
// - Regulator ramp lasts 5, 10, 15, 20 us
// - PA ramp lasts 5, 10, 15, 20 us
// - Retune soft settling 0 to 310 us
// - Post-calibration settling 0 to 70 us
// - Cold start settling is soft plus post-cal
// - Soft settling resets to 100 us
// - Post-cal settling resets to 20 us
// - Bad preamble window is threshold times four
// - Halving bit halves crystal wake wait
// - Fine RC calibration repeats every 30 s
// - Force bit rising starts 2 ms RC calibration
// - Wake-up timer enable triggers RC calibration
// - Double precision lengthens VCO calibration
// - Force bit runs one VCO calibration
// - Skip bit omits VCO calibration before transmit
module tx_ramp_pll_calibration_ctrl
  import txpll_pkg::*;
#(
  parameter int CYCLES_PER_US = CYC_PER_US,
  parameter int RC_CNT_W = 20,
  parameter logic [RC_CNT_W-1:0] RC_CAL_CYCLES = RC_CNT_W'(RC_CAL_CYC),
  parameter int FINE_CNT_W = 33,
  parameter logic [FINE_CNT_W-1:0] RC_FINE_CYCLES = FINE_CNT_W'(RC_FINE_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial register port
  input wire logic spi_sck,
  input wire logic spi_nsel,
  input wire logic spi_sdi,
  output logic spi_sdo,
  // Radio state inputs
  input wire logic pll_on,
  input wire logic tx_request,
  input wire logic retune_req,
  input wire logic wut_enable,
  input wire logic rc_osc_en,
  // Power-up path controls
  output tx_ctrl_t tx_ctrl,
  output logic vco_cal_busy,
  output logic vco_cal_long,
  output logic pll_settled,
  output logic rc_cal_busy,
  output logic xtal_wake_half,
  output logic [5:0] preamble_window
);

  localparam int TMR_W = 24;

  reg_req_t req;
  logic [7:0] ramp_reg;
  logic [7:0] tune_reg;
  logic [7:0] boost_reg;
  logic [7:0] cal_cfg;
  logic rc_force;
  logic vco_force;
  logic [7:0] rdata;
  seq_state_t state;
  seq_state_t next_state;
  logic [TMR_W-1:0] tmr;
  logic [TMR_W-1:0] next_tmr;
  logic tmr_done;

  serial_reg_port u_port (
    .core_clk(core_clk),
    .nrst(nrst),
    .spi_sck(spi_sck),
    .spi_nsel(spi_nsel),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .req(req),
    .rdata(rdata)
  );

  function automatic logic [TMR_W-1:0] us2cyc(input int us);
    return TMR_W'(us * CYCLES_PER_US);
  endfunction : us2cyc

  // Field decodes in cycles
  logic [TMR_W-1:0] mod_cyc;
  logic [TMR_W-1:0] ldo_cyc;
  logic [TMR_W-1:0] pa_cyc;
  logic [TMR_W-1:0] ts_cyc;
  logic [TMR_W-1:0] to_cyc;
  logic [TMR_W-1:0] vco_cyc;
  assign mod_cyc = us2cyc(int'(ramp_reg[MOD_LSB +: 3]) * MOD_STEP_US);
  assign ldo_cyc = us2cyc((int'(ramp_reg[LDO_LSB +: 2]) + 1) * RAMP_STEP_US);
  assign pa_cyc = us2cyc((int'(ramp_reg[PA_LSB +: 2]) + 1) * RAMP_STEP_US);
  assign ts_cyc = us2cyc(int'(tune_reg[TS_LSB +: 5]) * SETTLE_STEP_US);
  assign to_cyc = us2cyc(int'(tune_reg[TO_LSB +: 3]) * SETTLE_STEP_US);
  assign vco_cyc = us2cyc(cal_cfg[DP_BIT] ? 2 * VCO_CAL_US : VCO_CAL_US);

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ramp_reg <= RAMP_RST;
      tune_reg <= TUNE_RST;
      boost_reg <= BOOST_RST;
      cal_cfg <= CAL_RST & CAL_STORE_MASK;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_RAMP: ramp_reg <= req.wdata;
        ADDR_TUNE: tune_reg <= req.wdata;
        ADDR_BOOST: boost_reg <= req.wdata;
        ADDR_CAL: cal_cfg <= req.wdata & CAL_STORE_MASK;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read zero
  always_comb begin
    unique case (req.addr)
      ADDR_RAMP: rdata = ramp_reg;
      ADDR_TUNE: rdata = tune_reg;
      ADDR_BOOST: rdata = boost_reg;
      ADDR_CAL: rdata = cal_cfg | ({7'h00, rc_force} << RCCAL_BIT) | ({7'h00, vco_force} << VCOCAL_BIT);
      default: rdata = 8'h00;
    endcase
  end

  logic wr_cal;
  assign wr_cal = req.wr && req.addr == ADDR_CAL;

  ////////////////////////////////////////////////////////////////////////////
  // VCO calibration force bit; only taken in idle with the PLL running
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vco_force <= 1'b0;
    end else if (wr_cal && req.wdata[VCOCAL_BIT] && state == S_IDLE && pll_on) begin
      vco_force <= 1'b1;
    end else if (state == S_VCO_CAL && tmr_done) begin
      vco_force <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign tmr_done = tmr <= TMR_W'(1);

  always_comb begin
    next_state = state;
    next_tmr = (tmr == '0) ? tmr : tmr - TMR_W'(1);
    unique case (state)
      S_IDLE: begin
        if (vco_force && pll_on) begin
          next_state = S_VCO_CAL;
          next_tmr = vco_cyc;
        end else if (tx_request && cal_cfg[SKIP_BIT]) begin
          next_state = S_LDO_RAMP;
          next_tmr = ldo_cyc;
        end else if (tx_request) begin
          next_state = S_VCO_CAL;
          next_tmr = vco_cyc;
        end else if (retune_req && pll_on) begin
          next_state = S_SETTLE;
          next_tmr = ts_cyc;
        end
      end
      S_VCO_CAL: begin
        if (tmr_done) begin
          next_state = S_SETTLE;
          next_tmr = ts_cyc + to_cyc;
        end
      end
      S_SETTLE: begin
        if (tmr_done && tx_request) begin
          next_state = S_LDO_RAMP;
          next_tmr = ldo_cyc;
        end else if (tmr_done) begin
          next_state = S_IDLE;
        end
      end
      S_LDO_RAMP: begin
        if (tmr_done) begin
          next_state = S_PA_RAMP;
          next_tmr = pa_cyc;
        end
      end
      S_PA_RAMP: begin
        if (tmr_done) begin
          next_state = S_MOD_DLY;
          next_tmr = mod_cyc;
        end
      end
      S_MOD_DLY: begin
        if (tmr_done) begin
          next_state = S_TX;
        end
      end
      S_TX: begin
        if (!tx_request) begin
          next_state = S_RAMP_DOWN;
          next_tmr = mod_cyc;
        end
      end
      S_RAMP_DOWN: begin
        if (tmr_done) begin
          next_state = S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      tmr <= '0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
    end
  end

  // Outputs follow the next state so that they leave flip-flops in step with it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_ctrl <= '0;
      vco_cal_busy <= 1'b0;
      pll_settled <= 1'b0;
    end else begin
      tx_ctrl.ldo_ramp <= next_state inside {S_LDO_RAMP, S_PA_RAMP, S_MOD_DLY, S_TX, S_RAMP_DOWN};
      tx_ctrl.pa_en <= next_state inside {S_PA_RAMP, S_MOD_DLY, S_TX, S_RAMP_DOWN};
      tx_ctrl.mod_en <= next_state == S_TX;
      vco_cal_busy <= next_state == S_VCO_CAL;
      pll_settled <= pll_on && !(next_state inside {S_VCO_CAL, S_SETTLE});
    end
  end

  // Static controls to the oscillator and demodulator
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vco_cal_long <= 1'b0;
      xtal_wake_half <= 1'b0;
      preamble_window <= 6'h00;
    end else begin
      vco_cal_long <= cal_cfg[DP_BIT];
      xtal_wake_half <= cal_cfg[XHALF_BIT];
      preamble_window <= 6'(int'(boost_reg[PRE_LSB +: 4]) * PRE_MULT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // RC oscillator calibration; nothing starts while the oscillator is off
  logic wut_q;
  logic [FINE_CNT_W-1:0] fine_cnt;
  logic fine_tick;
  logic [RC_CNT_W-1:0] rc_cnt;
  logic rc_start;
  logic rc_end;

  assign fine_tick = fine_cnt == RC_FINE_CYCLES;
  assign rc_end = rc_cal_busy && rc_cnt <= RC_CNT_W'(1);
  assign rc_start = !rc_cal_busy && rc_osc_en && (rc_force || fine_tick || (wut_enable && !wut_q));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wut_q <= 1'b0;
      fine_cnt <= '0;
    end else begin
      wut_q <= wut_enable;
      if (!cal_cfg[FINE_BIT] || !rc_osc_en || fine_tick) begin
        fine_cnt <= '0;
      end else begin
        fine_cnt <= fine_cnt + FINE_CNT_W'(1);
      end
    end
  end

  // A new force request in the cycle a forced calibration ends is dropped; after a timer-started one it wins and restarts it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rc_force <= 1'b0;
    end else if (wr_cal && req.wdata[RCCAL_BIT] && !rc_force && rc_osc_en) begin
      rc_force <= 1'b1;
    end else if (rc_end || !rc_osc_en) begin
      rc_force <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rc_cal_busy <= 1'b0;
      rc_cnt <= '0;
    end else if (rc_start) begin
      rc_cal_busy <= 1'b1;
      rc_cnt <= RC_CAL_CYCLES;
    end else if (rc_end) begin
      rc_cal_busy <= 1'b0;
      rc_cnt <= '0;
    end else if (rc_cal_busy) begin
      rc_cnt <= rc_cnt - RC_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks: length of the state just left, compared to its programmed time
  logic [TMR_W-1:0] age;
  logic [TMR_W-1:0] prev_len;
  seq_state_t prev_state;
  logic settle_cold;

  function automatic logic [TMR_W-1:0] atleast1(input logic [TMR_W-1:0] c);
    return (c == '0) ? TMR_W'(1) : c;
  endfunction : atleast1

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      age <= '0;
      prev_len <= '0;
      prev_state <= S_IDLE;
      settle_cold <= 1'b0;
    end else if (next_state != state) begin
      age <= '0;
      prev_len <= age + TMR_W'(1);
      prev_state <= state;
      settle_cold <= state == S_VCO_CAL || (state == S_SETTLE && settle_cold);
    end else begin
      age <= age + TMR_W'(1);
    end
  end

  AST_MOD_UP_DELAY: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(tx_ctrl.mod_en) |-> tx_ctrl.pa_en && prev_len == atleast1(mod_cyc))
    else $error("modulation start delay wrong");

  AST_MOD_DOWN_DELAY: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(tx_ctrl.pa_en) |-> prev_state == S_RAMP_DOWN && prev_len == atleast1(mod_cyc))
    else $error("ramp-down delay wrong");

  AST_LDO_RAMP_TIME: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(tx_ctrl.pa_en) |-> tx_ctrl.ldo_ramp && prev_len == ldo_cyc)
    else $error("regulator ramp time wrong");

  AST_PA_RAMP_TIME: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == S_MOD_DLY && $past(state) == S_PA_RAMP) |-> !tx_ctrl.mod_en && prev_len == pa_cyc)
    else $error("PA ramp time wrong");

  AST_COLD_SETTLE: assert property (@(posedge core_clk) disable iff (!nrst)
    (prev_state == S_SETTLE && $past(state) == S_SETTLE && state != S_SETTLE && settle_cold)
      |-> prev_len == atleast1(ts_cyc + to_cyc))
    else $error("cold start settling time wrong");

  AST_TUNE_RESET: assert property (@(posedge core_clk)
    $rose(nrst) |-> tune_reg[TS_LSB +: 5] == TUNE_RST[TS_LSB +: 5] && tune_reg[TO_LSB +: 3] == TUNE_RST[TO_LSB +: 3])
    else $error("settling fields not at reset value");

  AST_RC_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(rc_cal_busy) && !$past(wr_cal) |-> !rc_force ##1 !rc_cal_busy || rc_force)
    else $error("RC force bit not cleared");

  AST_VCO_CLEAR: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(vco_cal_busy) |-> !vco_force && state == S_SETTLE)
    else $error("VCO force bit not cleared");

  AST_SKIP_VCO: assert property (@(posedge core_clk) disable iff (!nrst)
    (state == S_IDLE && tx_request && cal_cfg[SKIP_BIT] && !vco_force) |=> state == S_LDO_RAMP && !vco_cal_busy)
    else $error("VCO calibration not skipped");

endmodule : tx_ramp_pll_calibration_ctrl

/* File: hdl/txpll_pkg.sv */
package txpll_pkg;

  // Clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_US = 1000;
  localparam int US_PER_MS = 1000;
  localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;

  // Register offsets on the serial port
  localparam logic [6:0] ADDR_RAMP = 7'h52;
  localparam logic [6:0] ADDR_TUNE = 7'h53;
  localparam logic [6:0] ADDR_BOOST = 7'h54;
  localparam logic [6:0] ADDR_CAL = 7'h55;

  // Reset values; unknown bits come up as zero
  localparam logic [7:0] RAMP_RST = 8'h00;
  localparam logic [7:0] TUNE_RST = 8'h52;
  localparam logic [7:0] BOOST_RST = 8'h54;
  localparam logic [7:0] CAL_RST = 8'h44;

  // Writable stored bits of the calibration register (reserved bits read zero)
  localparam logic [7:0] CAL_STORE_MASK = 8'h55;

  // Field positions
  localparam int MOD_LSB = 4;
  localparam int LDO_LSB = 2;
  localparam int PA_LSB = 0;
  localparam int TS_LSB = 3;
  localparam int TO_LSB = 0;
  localparam int PRE_LSB = 2;
  localparam int XHALF_BIT = 6;
  localparam int FINE_BIT = 4;
  localparam int RCCAL_BIT = 3;
  localparam int DP_BIT = 2;
  localparam int VCOCAL_BIT = 1;
  localparam int SKIP_BIT = 0;

  // Timing steps in microseconds and long times in their own units
  localparam int MOD_STEP_US = 4;
  localparam int RAMP_STEP_US = 5;
  localparam int SETTLE_STEP_US = 10;
  localparam int VCO_CAL_US = 20;
  localparam int PRE_MULT = 4;
  localparam int RC_CAL_MS = 2;
  localparam int RC_FINE_S = 30;
  localparam int RC_CAL_CYC = RC_CAL_MS * US_PER_MS * CYC_PER_US;
  localparam longint RC_FINE_CYC = longint'(RC_FINE_S) * 64'd1000000000 / longint'(CLK_PERIOD_NS);

  typedef struct packed {
    logic wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic ldo_ramp;
    logic pa_en;
    logic mod_en;
  } tx_ctrl_t;

  typedef enum logic [2:0] {
    S_IDLE, S_VCO_CAL, S_SETTLE, S_LDO_RAMP, S_PA_RAMP, S_MOD_DLY, S_TX, S_RAMP_DOWN
  } seq_state_t;

endpackage : txpll_pkg

/* File: verif/spi_host.sv */
`timescale 1ns/10ps
module spi_host (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic spi_sck,
  output logic spi_nsel,
  output logic spi_sdi,
  input wire logic spi_sdo
);
  logic [7:0] rd_data;

  initial begin
    spi_sck = 1'b0;
    spi_nsel = 1'b1;
    spi_sdi = 1'b0;
    rd_data = 8'h00;
  end

  // Five core clocks per half period, above the port's one-clock minimum
  task automatic sck_half;
    repeat (5) @(negedge core_clk);
  endtask : sck_half

  // One whole frame: direction bit, 7 address bits, 8 data bits, MSB first
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    @(negedge core_clk);
    spi_nsel = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = frame[i];
      sck_half();
      if (i < 8) rd_data[i] = spi_sdo;
      spi_sck = 1'b1;
      sck_half();
      spi_sck = 1'b0;
    end
    sck_half();
    spi_nsel = 1'b1;
    // Released data line shows the inverse, so a stale bit never passes for data
    spi_sdi = ~spi_sdi;
    sck_half();
  endtask : xfer
endmodule : spi_host

/* File: verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import txpll_pkg::*;
  // Shortened time base keeps the run small; every expectation uses it
  localparam int CPU = 2;
  localparam int RC_CYC = 50;
  localparam int FINE_CYC = 200;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic spi_sck, spi_nsel, spi_sdi, spi_sdo;
  logic pll_on = 1'b0;
  logic tx_request = 1'b0;
  logic retune_req = 1'b0;
  logic wut_enable = 1'b0;
  logic rc_osc_en = 1'b0;
  tx_ctrl_t tx_ctrl;
  logic vco_cal_busy, vco_cal_long, pll_settled, rc_cal_busy, xtal_wake_half;
  logic [5:0] preamble_window;
  int failures = 0;
  int check_count = 0;
  int seed = 81;
  logic [31:0] exp_q[$];
  logic [31:0] got_val;
  logic [31:0] r;
  event got_ev;
  time t0, t_ldo, t_pa, t_mod, t_mod_f, t_pa_f, t_vr, t_vf, t_sf, t_sr, t_rr, t_rf;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  tx_ramp_pll_calibration_ctrl #(.CYCLES_PER_US(CPU), .RC_CAL_CYCLES(20'(RC_CYC)), .RC_FINE_CYCLES(33'(FINE_CYC)))
    tx_ramp_pll_calibration_ctrl_inst (.core_clk(core_clk), .nrst(nrst), .spi_sck(spi_sck),
    .spi_nsel(spi_nsel), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .pll_on(pll_on), .tx_request(tx_request),
    .retune_req(retune_req), .wut_enable(wut_enable), .rc_osc_en(rc_osc_en), .tx_ctrl(tx_ctrl),
    .vco_cal_busy(vco_cal_busy), .vco_cal_long(vco_cal_long), .pll_settled(pll_settled),
    .rc_cal_busy(rc_cal_busy), .xtal_wake_half(xtal_wake_half), .preamble_window(preamble_window));

  spi_host spi_host_inst (.core_clk(core_clk), .spi_sck(spi_sck), .spi_nsel(spi_nsel),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

  ////////////////////////////////////////////////////////////////
  // Edge time stamps and the result watcher
  always @(posedge tx_ctrl.ldo_ramp) t_ldo = $time;
  always @(posedge tx_ctrl.pa_en) t_pa = $time;
  always @(posedge tx_ctrl.mod_en) t_mod = $time;
  always @(negedge tx_ctrl.mod_en) t_mod_f = $time;
  always @(negedge tx_ctrl.pa_en) t_pa_f = $time;
  always @(posedge vco_cal_busy) t_vr = $time;
  always @(negedge vco_cal_busy) t_vf = $time;
  always @(negedge pll_settled) t_sf = $time;
  always @(posedge pll_settled) t_sr = $time;
  always @(posedge rc_cal_busy) t_rr = $time;
  always @(negedge rc_cal_busy) t_rf = $time;

  always @(got_ev) begin
    check_count++;
    if (exp_q.size() == 0 || got_val !== exp_q[0]) begin
      failures++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, (exp_q.size() > 0) ? exp_q[0] : 32'hx, got_val);
    end
    if (exp_q.size() > 0) void'(exp_q.pop_front());
  end

  ////////////////////////////////////////////////////////////////
  // Helpers
  // Rounds up: a level set at a falling edge is taken half a period later
  function automatic logic [31:0] cyc(input time a, input time b);
    return 32'((a - b + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : cyc

  task automatic expect_v(input logic [31:0] e);
    exp_q.push_back(e);
  endtask : expect_v

  task automatic post(input logic [31:0] g);
    got_val = g;
    ->got_ev;
    @(negedge core_clk);
  endtask : post

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    spi_host_inst.xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expect_v({24'h0, e});
    spi_host_inst.xfer(1'b0, a, 8'h00);
    post({24'h0, spi_host_inst.rd_data});
  endtask : rd

  task automatic pause(input int n);
    repeat (n) @(negedge core_clk);
  endtask : pause

  task automatic end_of_test;
    if (exp_q.size() != 0) failures++;
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) nrst = 1'b1;
    pause(2);
    expect_v(32'h14);
    post({26'h0, preamble_window});
    rd(ADDR_RAMP, 8'h00);
    rd(ADDR_TUNE, 8'h52);
    rd(ADDR_BOOST, 8'h54);
    rd(ADDR_CAL, 8'h44);
    rd(7'h60, 8'h00);
    $display("test reset done");
    // Force bits refused: PLL off and RC oscillator off
    wr(ADDR_CAL, 8'hff);
    rd(ADDR_CAL, 8'h55);
    expect_v(32'h3);
    post({30'h0, xtal_wake_half, vco_cal_long});
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      wr(ADDR_BOOST, r[7:0]);
      rd(ADDR_BOOST, r[7:0]);
      expect_v({26'h0, r[5:2], 2'b00});
      post({26'h0, preamble_window});
    end
    $display("test registers done");
    wr(ADDR_CAL, 8'h01);
    pll_on = 1'b1;
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_RAMP, {1'b0, 3'(2 * k + 1), 2'(k), 2'(3 - k)});
      expect_v(1);
      expect_v(5 * (k + 1) * CPU);
      expect_v(5 * (4 - k) * CPU + 4 * (2 * k + 1) * CPU);
      expect_v(4 * (2 * k + 1) * CPU);
      tx_request = 1'b1;
      t0 = $time;
      pause(300);
      post(cyc(t_ldo, t0));
      post(cyc(t_pa, t_ldo));
      post(cyc(t_mod, t_pa));
      tx_request = 1'b0;
      pause(100);
      post(cyc(t_pa_f, t_mod_f));
    end
    $display("test ramps done");
    // Cold start: longest soft and post-calibration times, double precision
    wr(ADDR_TUNE, 8'hff);
    wr(ADDR_CAL, 8'h04);
    expect_v(40 * CPU);
    expect_v(38 * 10 * CPU);
    tx_request = 1'b1;
    pause(1000);
    post(cyc(t_vf, t_vr));
    post(cyc(t_ldo, t_vf));
    tx_request = 1'b0;
    pause(100);
    wr(ADDR_TUNE, 8'h1a);
    expect_v(3 * 10 * CPU);
    retune_req = 1'b1;
    pause(1);
    retune_req = 1'b0;
    pause(200);
    post(cyc(t_sr, t_sf));
    wr(ADDR_CAL, 8'h02);
    pause(200);
    expect_v(20 * CPU);
    post(cyc(t_vf, t_vr));
    rd(ADDR_CAL, 8'h00);
    $display("test pll done");
    rc_osc_en = 1'b1;
    wr(ADDR_CAL, 8'h08);
    pause(100);
    expect_v(RC_CYC);
    post(cyc(t_rf, t_rr));
    rd(ADDR_CAL, 8'h00);
    t0 = $time;
    wut_enable = 1'b1;
    pause(100);
    expect_v(1);
    post(32'(t_rr > t0 && cyc(t_rf, t_rr) == RC_CYC));
    t0 = $time;
    wr(ADDR_CAL, 8'h10);
    pause(2 * FINE_CYC + 100);
    expect_v(1);
    post(32'(t_rr > t0));
    wr(ADDR_CAL, 8'h00);
    pause(100);
    // Oscillator off: the force request is dropped
    rc_osc_en = 1'b0;
    t0 = $time;
    wr(ADDR_CAL, 8'h08);
    pause(100);
    rd(ADDR_CAL, 8'h00);
    expect_v(0);
    post(32'(t_rr > t0));
    $display("test rc done");
    end_of_test();
  end
endmodule : testbench
